// ---- dfe_pkg.sv ----
// dfe_pkg: constants, field layouts and carrier types of the descriptor
// fetch engine.
// assumes a 32-bit plain register port and 32-byte descriptors.
package dfe_pkg;
  // ==========================================================
  // sizes
  localparam int NCH = 2;
  localparam int DSC_BYTES = 32;
  localparam int FIFO_BYTES = 32768;
  localparam int FIFO_DEPTH = FIFO_BYTES / DSC_BYTES;
  localparam int PTR_W = 10;
  localparam int CNT_W = 11;
  localparam int FIFO_MARGIN = 4;
  localparam int MAX_REQ_DSC = 32;
  localparam int MAX_BLK_DSC = 64;
  // ==========================================================
  // descriptor layout
  localparam logic [15:0] DSC_MAGIC = 16'hAD4B;
  localparam int W0_MAGIC_LSB = 16;
  localparam int W0_ADJ_LSB = 8;
  localparam int LEN_LSB = 32;
  localparam int SRC_LSB = 64;
  localparam int DST_LSB = 128;
  localparam int NXT_LSB = 192;
  localparam int CTL_STOP = 0;
  localparam int CTL_CMPL = 1;
  localparam int CTL_EOP = 4;
  // ==========================================================
  // register map
  localparam int CH_SEL_BIT = 6;
  localparam int GLOBAL_BIT = 7;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STAT = 6'h04;
  localparam logic [5:0] REG_START_LO = 6'h08;
  localparam logic [5:0] REG_START_HI = 6'h0C;
  localparam logic [5:0] REG_FIRST_ADJ = 6'h10;
  localparam logic [7:0] REG_MRRS = 8'h80;
  localparam logic [7:0] REG_LEVEL = 8'h84;
  localparam int CR_RUN = 0;
  localparam int CR_CMPL_IE = 1;
  localparam int CR_STOP_IE = 2;
  localparam int CR_BYP = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_STOPPED = 1;
  localparam int ST_MAGIC_ERR = 2;
  localparam int ST_REM_LSB = 8;
  localparam logic [2:0] MRRS_RST = 3'h2;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] ctrl;
    logic [27:0] len;
    logic [63:0] src;
    logic [63:0] dst;
  } dfe_byp_t;
  typedef struct packed {
    logic magic_ok;
    logic [5:0] adj;
    dfe_byp_t body;
    logic [63:0] nxt;
  } dfe_dsc_t;
  typedef struct packed {
    logic chan;
    logic irq;
    logic eop;
    logic stop;
    logic [27:0] len;
    logic [63:0] src;
    logic [63:0] dst;
  } dfe_ent_t;
  typedef enum logic [1:0] {FS_IDLE, FS_REQ, FS_WAIT} dfe_fs_t;
  typedef struct packed {
    logic run;
    logic cmpl_ie;
    logic stop_ie;
    logic byp;
    logic [63:0] start;
    logic [5:0] first_adj;
    logic [63:0] nxt;
    logic [6:0] rem;
    logic stopped;
    logic err;
  } dfe_ch_t;
endpackage : dfe_pkg

// ---- dfe_decode.sv ----
// dfe_decode: splits one raw 256-bit descriptor into its fields.
// assumes word 0 sits in the low 32 bits of the raw vector.
`timescale 1ns/1ps
module dfe_decode
  import dfe_pkg::*;
(
  // raw descriptor
  input wire logic [255:0] i_raw,
  // decoded fields
  output dfe_dsc_t o_dsc
);
  // ==========================================================
  // field split, one process so the port has a single driver
  always_comb begin
    o_dsc = '0;
    o_dsc.magic_ok = (i_raw[W0_MAGIC_LSB +: 16] == DSC_MAGIC);
    o_dsc.adj = i_raw[W0_ADJ_LSB +: 6];
    o_dsc.body.ctrl = i_raw[7:0];
    // top nibble of the length word is dropped, not checked
    o_dsc.body.len = i_raw[LEN_LSB +: 28];
    o_dsc.body.src = i_raw[SRC_LSB +: 64];
    o_dsc.body.dst = i_raw[DST_LSB +: 64];
    o_dsc.nxt = i_raw[NXT_LSB +: 64];
  end
endmodule : dfe_decode

// ---- dfe_fifo.sv ----
// dfe_fifo: shared descriptor store with a registered output stage.
// assumes the writer never pushes into a full store.
`timescale 1ns/1ps
module dfe_fifo
  import dfe_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // write side
  input wire logic i_push,
  input dfe_ent_t i_ent,
  // read side
  output dfe_ent_t o_ent,
  output logic o_valid,
  input wire logic i_ready,
  // fill level, output stage included
  output logic [CNT_W-1:0] o_level
);
  typedef struct packed {
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [CNT_W-1:0] cnt;
    logic valid;
    dfe_ent_t ent;
  } dfe_fst_t;

  dfe_ent_t mem [FIFO_DEPTH];
  dfe_fst_t s_q;
  dfe_fst_t s_d;
  logic wr_ok;
  logic pop;

  // ==========================================================
  // next state
  assign wr_ok = i_push && (s_q.cnt < CNT_W'(FIFO_DEPTH));
  always_comb begin
    s_d = s_q;
    pop = (s_q.cnt != '0) && (!s_q.valid || i_ready);
    if (s_q.valid && i_ready) begin
      s_d.valid = 1'b0;
    end
    if (pop) begin
      s_d.valid = 1'b1;
      s_d.ent = mem[s_q.rp];
      s_d.rp = s_q.rp + PTR_W'(1);
    end
    if (wr_ok) begin
      s_d.wp = s_q.wp + PTR_W'(1);
    end
    s_d.cnt = s_q.cnt + CNT_W'(wr_ok) - CNT_W'(pop);
  end

  // ==========================================================
  // storage, no reset on the array to keep it a plain memory
  always_ff @(posedge i_clk) begin
    if (wr_ok) begin
      mem[s_q.wp] <= i_ent;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ent = s_q.ent;
  assign o_valid = s_q.valid;
  assign o_level = s_q.cnt + CNT_W'(s_q.valid);
endmodule : dfe_fifo

// ---- dfe_engine.sv ----
// dfe_engine: per-channel descriptor fetch and bypass engine.
// assumes a host read port that returns one 256-bit descriptor per beat,
// in order, and a consumer draining the shared descriptor store.
`timescale 1ns/1ps
module dfe_engine
  import dfe_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // host descriptor read request
  output logic o_rd_valid,
  output logic [63:0] o_rd_addr,
  output logic [5:0] o_rd_count,
  input wire logic i_rd_ready,
  // host completion, one descriptor per beat
  input wire logic i_cpl_valid,
  input wire logic [255:0] i_cpl_data,
  output logic o_cpl_ready,
  // bypass buses
  input wire logic i_host_to_card_bypass_valid,
  input dfe_byp_t i_host_to_card_bypass_bus,
  output logic o_host_to_card_bypass_ready,
  input wire logic i_card_to_host_bypass_valid,
  input dfe_byp_t i_card_to_host_bypass_bus,
  output logic o_card_to_host_bypass_ready,
  // descriptor stream out
  output logic o_dsc_valid,
  output dfe_ent_t o_dsc,
  input wire logic i_dsc_ready
);
  typedef struct packed {
    dfe_ch_t [NCH-1:0] ch;
    dfe_fs_t fs;
    logic cur;
    logic rr;
    logic turn;
    logic [5:0] left;
    logic bad;
    logic [2:0] mrrs;
    logic rd_valid;
    logic [63:0] rd_addr;
    logic [5:0] rd_count;
    logic cpl_ready;
    logic [NCH-1:0] byp_ready;
    logic [31:0] rdata;
  } dfe_st_t;

  // ==========================================================
  // helpers
  function automatic logic [6:0] dfe_min(logic [6:0] a, logic [6:0] b);
    dfe_min = (a < b) ? a : b;
  endfunction : dfe_min

  function automatic logic [6:0] dfe_mrrs_dsc(logic [2:0] code);
    // read limit is 128 bytes shifted by code, held at the code 3 value above that, four descriptors per 128
    if (code >= 3'h3) begin
      dfe_mrrs_dsc = 7'(MAX_REQ_DSC);
    end else begin
      dfe_mrrs_dsc = 7'h04 << code;
    end
  endfunction : dfe_mrrs_dsc

  function automatic dfe_ent_t dfe_mk_ent(logic chan, logic ie,
                                          dfe_byp_t b);
    dfe_ent_t e;
    e.chan = chan;
    e.irq = b.ctrl[CTL_CMPL] & ie;
    e.eop = b.ctrl[CTL_EOP];
    e.stop = b.ctrl[CTL_STOP];
    e.len = b.len;
    // addresses go out as written, no card-side translation
    e.src = b.src;
    e.dst = b.dst;
    return e;
  endfunction : dfe_mk_ent

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  dfe_st_t s_q;
  dfe_st_t s_d;
  dfe_dsc_t dec;
  dfe_ent_t push_ent;
  logic push;
  logic [CNT_W-1:0] level;
  logic [NCH-1:0] byp_valid;
  dfe_byp_t [NCH-1:0] byp_bus;
  logic [NCH-1:0] byp_acc;
  logic cpl_acc;
  logic room_ok;
  logic [6:0] room_dsc;

  assign byp_valid = {i_card_to_host_bypass_valid,
                      i_host_to_card_bypass_valid};
  assign byp_bus = {i_card_to_host_bypass_bus, i_host_to_card_bypass_bus};
  assign byp_acc = byp_valid & s_q.byp_ready;
  assign cpl_acc = i_cpl_valid && s_q.cpl_ready;
  // margin covers pushes still in flight behind a registered ready
  assign room_ok = (level + CNT_W'(FIFO_MARGIN)) < CNT_W'(FIFO_DEPTH);
  assign room_dsc = !room_ok ? 7'h00 :
    ((CNT_W'(FIFO_DEPTH) - level - CNT_W'(FIFO_MARGIN)) >
     CNT_W'(MAX_BLK_DSC)) ? 7'(MAX_BLK_DSC) :
    7'(CNT_W'(FIFO_DEPTH) - level - CNT_W'(FIFO_MARGIN));

  dfe_decode u_decode (
    .i_raw (i_cpl_data),
    .o_dsc (dec)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic rsel;
    logic [5:0] roff;
    logic [NCH-1:0] elig;
    logic sel;
    logic [6:0] cnt;
    logic bad_now;
    rsel = i_reg_addr[CH_SEL_BIT];
    roff = i_reg_addr[5:0];
    elig = '0;
    sel = 1'b0;
    cnt = '0;
    bad_now = 1'b0;
    s_d = s_q;
    push = 1'b0;
    push_ent = '0;
    s_d.rdata = '0;
    // register writes first so that hardware events below win
    if (i_reg_wr && !i_reg_addr[GLOBAL_BIT]) begin
      case (roff)
        REG_CTRL: begin
          if (i_reg_wdata[CR_RUN] && !s_q.ch[rsel].run) begin
            s_d.ch[rsel].nxt = s_q.ch[rsel].start;
            s_d.ch[rsel].rem = 7'(s_q.ch[rsel].first_adj) + 7'h01;
            s_d.ch[rsel].stopped = 1'b0;
            s_d.ch[rsel].err = 1'b0;
          end
          s_d.ch[rsel].run = i_reg_wdata[CR_RUN];
          s_d.ch[rsel].cmpl_ie = i_reg_wdata[CR_CMPL_IE];
          s_d.ch[rsel].stop_ie = i_reg_wdata[CR_STOP_IE];
          s_d.ch[rsel].byp = i_reg_wdata[CR_BYP];
        end
        REG_START_LO: s_d.ch[rsel].start[31:0] = i_reg_wdata;
        REG_START_HI: s_d.ch[rsel].start[63:32] = i_reg_wdata;
        REG_FIRST_ADJ: s_d.ch[rsel].first_adj = i_reg_wdata[5:0];
        default: ;
      endcase
    end
    if (i_reg_wr && i_reg_addr == REG_MRRS) begin
      s_d.mrrs = i_reg_wdata[2:0];
    end
    if (i_reg_rd && !i_reg_addr[GLOBAL_BIT]) begin
      case (roff)
        REG_CTRL: s_d.rdata = {28'h0000000, s_q.ch[rsel].byp,
          s_q.ch[rsel].stop_ie, s_q.ch[rsel].cmpl_ie, s_q.ch[rsel].run};
        REG_STAT: begin
          s_d.rdata[ST_BUSY] = (s_q.fs != FS_IDLE) && (s_q.cur == rsel);
          s_d.rdata[ST_STOPPED] = s_q.ch[rsel].stopped;
          s_d.rdata[ST_MAGIC_ERR] = s_q.ch[rsel].err;
          s_d.rdata[ST_REM_LSB +: 7] = s_q.ch[rsel].rem;
        end
        REG_START_LO: s_d.rdata = s_q.ch[rsel].start[31:0];
        REG_START_HI: s_d.rdata = s_q.ch[rsel].start[63:32];
        REG_FIRST_ADJ: s_d.rdata = {26'h0000000, s_q.ch[rsel].first_adj};
        default: ;
      endcase
    end else if (i_reg_rd && i_reg_addr == REG_MRRS) begin
      s_d.rdata = {29'h00000000, s_q.mrrs};
    end else if (i_reg_rd && i_reg_addr == REG_LEVEL) begin
      s_d.rdata = {21'h000000, level};
    end
    // fetch sequencer, one request outstanding at a time
    unique case (s_q.fs)
      FS_IDLE: begin
        for (int c = 0; c < NCH; c++) begin
          elig[c] = s_q.ch[c].run && !s_q.ch[c].byp &&
            !s_q.ch[c].stopped && !s_q.ch[c].err &&
            (s_q.ch[c].rem != 7'h00);
        end
        sel = elig[s_q.rr] ? s_q.rr : ~s_q.rr;
        cnt = dfe_min(dfe_min(s_q.ch[sel].rem, dfe_mrrs_dsc(s_q.mrrs)),
                      room_dsc);
        if (elig[sel] && cnt != 7'h00) begin
          s_d.rd_valid = 1'b1;
          s_d.rd_addr = s_q.ch[sel].nxt;
          s_d.rd_count = 6'(cnt);
          s_d.cur = sel;
          s_d.rr = ~sel;
          s_d.fs = FS_REQ;
        end
      end
      FS_REQ: begin
        if (i_rd_ready) begin
          s_d.rd_valid = 1'b0;
          s_d.left = s_q.rd_count;
          s_d.bad = 1'b0;
          s_d.fs = FS_WAIT;
        end
      end
      FS_WAIT: begin
        if (cpl_acc) begin
          bad_now = s_q.bad || !dec.magic_ok;
          // later beats of a request after a bad magic are dropped
          if (!bad_now) begin
            push = 1'b1;
            push_ent = dfe_mk_ent(s_q.cur, s_q.ch[s_q.cur].cmpl_ie,
                                  dec.body);
          end
          s_d.bad = bad_now;
          s_d.left = s_q.left - 6'h01;
          if (s_q.left == 6'h01) begin
            s_d.fs = FS_IDLE;
            if (bad_now) begin
              s_d.ch[s_q.cur].err = 1'b1;
              s_d.ch[s_q.cur].rem = 7'h00;
            end else if (dec.body.ctrl[CTL_STOP]) begin
              s_d.ch[s_q.cur].stopped = 1'b1;
              s_d.ch[s_q.cur].rem = 7'h00;
            end else begin
              // last fetched descriptor names the next address and block
              s_d.ch[s_q.cur].nxt = dec.nxt;
              s_d.ch[s_q.cur].rem = 7'(dec.adj) + 7'h01;
            end
          end
        end
      end
      default: s_d.fs = FS_IDLE;
    endcase
    s_d.cpl_ready = (s_d.fs == FS_WAIT);
    // bypass: one channel offered per cycle, halves each channel's peak
    // rate but keeps a single write port on the store
    s_d.turn = ~s_q.turn;
    for (int c = 0; c < NCH; c++) begin
      if (byp_acc[c]) begin
        push = 1'b1;
        push_ent = dfe_mk_ent(1'(c), s_q.ch[c].cmpl_ie, byp_bus[c]);
      end
      s_d.byp_ready[c] = s_d.ch[c].run && s_d.ch[c].byp &&
        (s_d.fs == FS_IDLE) && (s_d.turn == 1'(c)) && room_ok;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.fs <= FS_IDLE;
      s_q.mrrs <= MRRS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  dfe_fifo u_fifo (
    .i_clk (i_clk),
    .i_rst_n (rst_n),
    .i_push (push),
    .i_ent (push_ent),
    .o_ent (o_dsc),
    .o_valid (o_dsc_valid),
    .i_ready (i_dsc_ready),
    .o_level (level)
  );

  assign o_reg_rdata = s_q.rdata;
  assign o_rd_valid = s_q.rd_valid;
  assign o_rd_addr = s_q.rd_addr;
  assign o_rd_count = s_q.rd_count;
  assign o_cpl_ready = s_q.cpl_ready;
  assign o_host_to_card_bypass_ready = s_q.byp_ready[0];
  assign o_card_to_host_bypass_ready = s_q.byp_ready[1];

  // ==========================================================
  // checks
  logic pick;
  logic pick_run;
  logic [63:0] pick_nxt;
  logic [6:0] pick_rem;
  logic fin_stop;
  logic fin_bad;
  assign pick = (s_q.fs == FS_IDLE) && (s_d.fs == FS_REQ);
  assign pick_run = s_q.ch[s_d.cur].run;
  assign pick_nxt = s_q.ch[s_d.cur].nxt;
  assign pick_rem = s_q.ch[s_d.cur].rem;
  assign fin_stop = (s_q.fs == FS_WAIT) && cpl_acc && s_q.left == 6'h01 &&
    dec.magic_ok && !s_q.bad && dec.body.ctrl[CTL_STOP];
  assign fin_bad = (s_q.fs == FS_WAIT) && cpl_acc && s_q.left == 6'h01 &&
    (s_q.bad || !dec.magic_ok);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_fetch_needs_run: assert property (
    pick |-> pick_run)
    else $error("fetch started on a channel without run");
  a_fetch_addr: assert property (
    pick |=> o_rd_valid && o_rd_addr == $past(pick_nxt))
    else $error("read request address is not the channel next address");
  a_req_fits: assert property (
    pick |=> o_rd_count <= $past(pick_rem))
    else $error("read request exceeds adjacent count");
  a_req_cap: assert property (
    o_rd_valid |-> o_rd_count >= 6'h01 && o_rd_count <= 6'h20)
    else $error("read request descriptor count out of range");
  a_stop_halts: assert property (
    fin_stop |=> s_q.ch[$past(s_q.cur)].stopped &&
      !(pick && s_d.cur == $past(s_q.cur)))
    else $error("stop bit did not halt the list");
  a_magic_gate: assert property (
    ((s_q.fs == FS_WAIT) && cpl_acc && !dec.magic_ok) |-> !push)
    else $error("descriptor with wrong magic was stored");
  a_byp_run: assert property (
    byp_acc[0] |-> s_q.ch[0].run && push)
    else $error("bypass descriptor taken without run");
  a_byp_stored: assert property (
    (|byp_acc) |-> push && !cpl_acc ##1 o_dsc_valid || level != '0)
    else $error("bypass descriptor was not stored");
  a_err_flag: assert property (
    fin_bad |=> s_q.ch[$past(s_q.cur)].err &&
      !(pick && s_d.cur == $past(s_q.cur)))
    else $error("wrong magic did not raise the error flag");

  c_fetch_done: cover property (pick ##[1:40] fin_stop);
  c_bad_magic: cover property (fin_bad);
  c_byp_burst: cover property ((|byp_acc) ##2 (|byp_acc));
endmodule : dfe_engine

// ---- dfe_host_model.sv ----
// dfe_host_model: host memory answering descriptor read requests.
// assumes one request outstanding and one whole descriptor per beat.
`timescale 1ns/1ps
module dfe_host_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // answer delay in cycles
  input wire logic [3:0] i_slow,
  // read request
  input wire logic i_rd_valid,
  input wire logic [63:0] i_rd_addr,
  input wire logic [5:0] i_rd_count,
  output logic o_rd_ready,
  // completion beats
  output logic o_cpl_valid,
  output logic [255:0] o_cpl_data,
  input wire logic i_cpl_ready
);
  // =====
  // memory: one 32-byte slot per descriptor inside one 4K page
  logic [255:0] mem [0:127];
  logic [6:0] ptr;
  logic [6:0] left;
  logic [3:0] dly;
  logic [255:0] last;

  assign o_cpl_valid = left != 7'h00;
  // released data shows the inverse of the last beat, never a stale copy
  assign o_cpl_data = o_cpl_valid ? mem[ptr] : ~last;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_ready <= 1'b0;
      left <= 7'h00;
      ptr <= 7'h00;
      dly <= 4'h0;
      last <= '0;
    end else begin
      o_rd_ready <= 1'b0;
      if (i_rd_valid && !o_rd_ready && left == 7'h00) begin
        if (dly == i_slow) begin
          o_rd_ready <= 1'b1;
          dly <= 4'h0;
        end else begin
          dly <= dly + 4'h1;
        end
      end
      if (i_rd_valid && o_rd_ready) begin
        left <= {1'b0, i_rd_count};
        ptr <= i_rd_addr[11:5];
      end
      if (o_cpl_valid && i_cpl_ready) begin
        left <= left - 7'h01;
        ptr <= ptr + 7'h01;
        last <= mem[ptr];
      end
    end
  end
endmodule : dfe_host_model

// ---- dfe_tb.sv ----
// dfe_tb: self-checking bench of the descriptor fetch engine.
// assumes the host model answers reads; the bench drives registers,
// bypass buses and the consumer side.
`timescale 1ns/1ps
module testbench;
  import dfe_pkg::*;
  logic i_clk, i_rst_n, reg_wr, reg_rd, dsc_ready, dsc_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic rd_valid, rd_ready, cpl_valid, cpl_ready, bv0, bv1, br0, br1;
  logic [63:0] rd_addr;
  logic [5:0] rd_count;
  logic [255:0] cpl_data;
  logic [3:0] slow;
  dfe_byp_t bb0, bb1;
  dfe_ent_t dsc;
  int errors, checks;
  logic [69:0] reqq[$];
  dfe_ent_t entq[$];

  dfe_engine dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_rd_valid(rd_valid), .o_rd_addr(rd_addr),
    .o_rd_count(rd_count), .i_rd_ready(rd_ready), .i_cpl_valid(cpl_valid),
    .i_cpl_data(cpl_data), .o_cpl_ready(cpl_ready),
    .i_host_to_card_bypass_valid(bv0), .i_host_to_card_bypass_bus(bb0),
    .o_host_to_card_bypass_ready(br0), .i_card_to_host_bypass_valid(bv1),
    .i_card_to_host_bypass_bus(bb1), .o_card_to_host_bypass_ready(br1),
    .o_dsc_valid(dsc_valid), .o_dsc(dsc), .i_dsc_ready(dsc_ready));
  dfe_host_model host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .i_rd_count(rd_count),
    .o_rd_ready(rd_ready), .o_cpl_valid(cpl_valid), .o_cpl_data(cpl_data),
    .i_cpl_ready(cpl_ready));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // =====
  // monitors: taken requests and consumed descriptors
  always @(posedge i_clk) begin
    if (rd_valid && rd_ready) reqq.push_back({rd_addr, rd_count});
    if (dsc_valid && dsc_ready) entq.push_back(dsc);
  end

  // =====
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  task automatic cmp(input logic [255:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic waitn(input bit e, input int n);
    for (int i = 0; i < 800; i++) begin
      if ((e ? entq.size() : reqq.size()) >= n) return;
      @(posedge i_clk);
    end
    // a wait that runs out is a failure in its own right
    errors++;
  endtask : waitn
  function automatic logic [255:0] mk(input logic [15:0] mg,
    input logic [5:0] adj, input logic [7:0] ctl, input int k,
    input logic [63:0] nxt);
    return {nxt, 64'hB000 + k, 64'hA000 + k, 4'h0, 28'h100 + k[27:0],
      mg, 2'b00, adj, ctl};
  endfunction : mk
  function automatic dfe_ent_t ent(input logic ch, i, e, s, input int k);
    return {ch, i, e, s, 28'h100 + k[27:0], 64'hA000 + k, 64'hB000 + k};
  endfunction : ent
  task automatic byp(input logic ch, input int k, input logic [7:0] ctl,
    output logic ok);
    dfe_byp_t b;
    b = {ctl, 28'h100 + k[27:0], 64'hA000 + k, 64'hB000 + k};
    ok = 1'b0;
    @(posedge i_clk);
    if (ch) begin
      bv1 <= 1'b1;
      bb1 <= b;
    end else begin
      bv0 <= 1'b1;
      bb0 <= b;
    end
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge i_clk);
      ok = ch ? br1 : br0;
    end
    bv0 <= 1'b0;
    bv1 <= 1'b0;
  endtask : byp

  // =====
  // scenarios
  task automatic t_reset;
    rd(8'h00, v); cmp(v, 32'h0);
    rd(8'h80, v); cmp(v, 32'h2);
    rd(8'h84, v); cmp(v, 32'h0);
    wr(8'h88, 32'hFFFF_FFFF);
    rd(8'h88, v); cmp(v, 32'h0);
    wr(8'h08, 32'h0000_1000);
    wr(8'h10, 32'h5);
    cyc(20);
    cmp(reqq.size(), 0);
  endtask : t_reset

  task automatic t_fetch;
    logic [63:0] a, n;
    logic [5:0] adj;
    logic [7:0] ctl;
    // block of six at 0x1000 chained to a block of two at 0x1400
    for (int k = 0; k < 8; k++) begin
      a = k < 6 ? 64'h1000 + 32 * k : 64'h1400 + 32 * (k - 6);
      n = k == 5 ? 64'h1400 : k == 7 ? 64'h0 : a + 64'h20;
      adj = k < 5 ? 6'(4 - k) : k == 5 ? 6'h1 : 6'h0;
      ctl = k == 1 ? 8'h02 : k == 2 ? 8'h10 : k == 7 ? 8'h01 : 8'h00;
      host.mem[a[11:5]] = mk(DSC_MAGIC, adj, ctl, k, n);
    end
    slow <= 4'h3;
    dsc_ready <= 1'b0;
    wr(8'h80, 32'h0);
    wr(8'h00, 32'h3);
    waitn(1'b0, 3);
    cyc(20);
    rd(8'h84, v); cmp(v, 32'h8);
    @(posedge i_clk);
    dsc_ready <= 1'b1;
    waitn(1'b1, 8);
    cmp(reqq[0], {64'h1000, 6'h04});
    cmp(reqq[1], {64'h1080, 6'h02});
    cmp(reqq[2], {64'h1400, 6'h02});
    for (int k = 0; k < 8; k++) begin
      cmp(entq[k], ent(1'b0, k == 1, k == 2, k == 7, k));
    end
    cyc(20);
    cmp(reqq.size(), 3);
    rd(8'h04, v); cmp(v[2:0], 3'b010);
  endtask : t_fetch

  task automatic t_magic;
    @(posedge i_clk);
    slow <= 4'h0;
    host.mem[64] = mk(16'h1234, 6'h0, 8'h00, 9, 64'h0);
    wr(8'h48, 32'h0000_1800);
    wr(8'h50, 32'h0);
    wr(8'h40, 32'h1);
    waitn(1'b0, 4);
    cyc(20);
    cmp(reqq[3], {64'h1800, 6'h01});
    cmp(entq.size(), 8);
    rd(8'h44, v); cmp(v[2:0], 3'b100);
  endtask : t_magic

  task automatic t_bypass;
    logic ok;
    wr(8'h00, 32'h0);
    wr(8'h00, 32'hD);
    byp(1'b0, 20, 8'h12, ok); cmp(ok, 1'b1);
    wr(8'h40, 32'h0);
    wr(8'h40, 32'h8);
    byp(1'b1, 30, 8'h00, ok); cmp(ok, 1'b0);
    wr(8'h40, 32'hB);
    byp(1'b1, 21, 8'h02, ok); cmp(ok, 1'b1);
    rd(8'h40, v); cmp(v, 32'hB);
    waitn(1'b1, 10);
    cmp(entq[8], ent(1'b0, 1'b0, 1'b1, 1'b0, 20));
    cmp(entq[9], ent(1'b1, 1'b1, 1'b0, 1'b0, 21));
    cmp(entq.size(), 10);
  endtask : t_bypass

  // =====
  // run and verdict
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    i_rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    dsc_ready = 1'b1;
    bv0 = 1'b0;
    bv1 = 1'b0;
    bb0 = '0;
    bb1 = '0;
    slow = 4'h0;
    errors = 0;
    checks = 0;
    cyc(6);
    i_rst_n <= 1'b1;
    cyc(3);
    t_reset;
    t_fetch;
    t_magic;
    t_bypass;
    report_and_stop;
  end

  // the whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    cyc(20000);
    errors++;
    report_and_stop;
  end
endmodule : testbench
